// ---- hw/mcs_bank.sv ----
// Monitor control and first status register bank with an AHB-Lite slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module mcs_bank #(
  parameter int FAN_COUNT = 3,
  parameter int DUTY_W    = 8
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic [31:0]                        hrdata,
  output logic                               hresp,
  // Limit conditions from the sensing logic, high while out of range
  input  wire logic                          v2p5_cond,
  input  wire logic                          alert_timer_cond,
  input  wire logic                          pin_is_alert,
  input  wire logic                          core_volt_cond,
  input  wire logic                          supply_volt_cond,
  input  wire logic                          v5_cond,
  input  wire logic                          remote1_cond,
  input  wire logic                          local_cond,
  input  wire logic                          remote2_cond,
  input  wire logic [7:0]                    status2_bits,
  // Thermal override sources
  input  wire logic                          thermal_alert_in,
  input  wire logic                          cpu_ctrl_limit,
  // Duty computed by the fan control loop for each channel
  input  wire logic [FAN_COUNT-1:0][DUTY_W-1:0] calc_duty,
  // Outputs to the rest of the monitor
  output logic [FAN_COUNT-1:0][DUTY_W-1:0]   fan_duty,
  output logic                               monitor_run,
  output logic                               use_prog_limits,
  output logic                               limits_frozen,
  output logic                               cpu_thermal_poll_en
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (FAN_COUNT < 1 || FAN_COUNT > 8)
  begin : g_chk_fan
    $error("mcs_bank: FAN_COUNT must be 1 to 8");
  end
  if (DUTY_W < 2 || DUTY_W > 16)
  begin : g_chk_duty
    $error("mcs_bank: DUTY_W must be 2 to 16");
  end
  // Status flags plus the summary must fill exactly one byte
  if (mcs_pkg::STAT_COND_W != mcs_pkg::SUMMARY_BIT)
  begin : g_chk_stat
    $error("mcs_bank: status flags must fill the bits below the summary");
  end

  // ----------------------------------------------------------------
  // Bus transfer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCS_IDLE = 2'b01,
    MCS_DATA = 2'b10
  } mcs_bus_state_t;

  mcs_bus_state_t state_q;
  mcs_bus_state_t state_d;
  logic [9:0]     addr_q;
  logic           write_q;
  logic           take;
  logic           do_wr;
  logic           do_rd;
  logic           hit_ctrl;
  logic           hit_stat;
  logic [7:0]     rdata;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic           run_q;
  logic           lock_q;
  logic           rdy_q;
  logic           boost_q;
  logic           poll_q;
  logic           alert_q;
  logic           summary_q;
  logic [7:0]     ctrl_view;
  logic [7:0]     stat_view;
  logic [6:0]     stat_cond;
  logic [6:0]     stat_flags;
  logic           stat_rd_clr;
  logic           bit0_cond;

  mcs_ctl_if ctl_bus ();

  // Word address compare used for both registers
  function automatic logic addr_is(input logic [9:0] a, input logic [9:0] reg_addr);
    addr_is = (a[9:2] == reg_addr[9:2]);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  // Only NONSEQ is taken; every access gets one wait state so that
  // read data can come straight from a flip-flop.
  // Only haddr[9:2] is decoded, so each register is one aligned word.
  assign take = hsel && hready && (htrans == mcs_pkg::HTRANS_NONSEQ)
                && (state_q == MCS_IDLE);

  // Next transfer state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MCS_IDLE:
      begin
        if (take)
          state_d = MCS_DATA;
      end
      MCS_DATA:
      begin
        state_d = MCS_IDLE;
      end
      default:
      begin
        state_d = MCS_IDLE;
      end
    endcase
  end

  // Transfer state register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_q <= MCS_IDLE;
    else
      state_q <= state_d;
  end

  // Address phase capture; hsize is word only and is not decoded
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      addr_q  <= '0;
      write_q <= 1'b0;
    end
    else if (take)
    begin
      addr_q  <= haddr[9:0];
      write_q <= hwrite;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite data phase
  // ----------------------------------------------------------------
  assign do_wr    = (state_q == MCS_DATA) && write_q;
  assign do_rd    = (state_q == MCS_DATA) && !write_q;
  assign hit_ctrl = addr_is(addr_q, mcs_pkg::CTRL_ADDR);
  assign hit_stat = addr_is(addr_q, mcs_pkg::STAT1_ADDR);

  // Wait state: low in the cycle after the address is taken
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hreadyout <= 1'b1;
    else
      hreadyout <= (state_d == MCS_IDLE);
  end

  // Always OKAY, unmapped words included
  // Kept in a flop so that every bus output leaves from a register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata = 8'h00;
    if (hit_ctrl)
      rdata = ctrl_view;
    else if (hit_stat)
      rdata = stat_view;
  end

  // Read data registered at the edge that ends the wait state
  // Zeroed when a read is taken, so data from an older read is never
  // mistaken for this one while the wait state runs
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hrdata <= '0;
    else if (take && !hwrite)
      hrdata <= '0;
    else if (do_rd)
      hrdata <= {24'h000000, rdata};
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reserved bits 7:6 are constant zero and never stored
  assign ctrl_view = {2'b00, alert_q, poll_q, boost_q, rdy_q, lock_q, run_q};

  // Run and full override stay writable under the freeze
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      run_q   <= mcs_pkg::CTRL_RESET[mcs_pkg::RUN_BIT];
      boost_q <= mcs_pkg::CTRL_RESET[mcs_pkg::BOOST_BIT];
    end
    else if (do_wr && hit_ctrl)
    begin
      run_q   <= hwdata[mcs_pkg::RUN_BIT];
      boost_q <= hwdata[mcs_pkg::BOOST_BIT];
    end
  end

  // Freeze is write-once: only reset, i.e. a power cycle, clears it
  // A zero written to the freeze bit is ignored: software can never
  // unlock the limits, which is the point of the freeze
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      lock_q <= mcs_pkg::CTRL_RESET[mcs_pkg::LOCK_BIT];
    else if (do_wr && hit_ctrl && !lock_q && hwdata[mcs_pkg::LOCK_BIT])
      lock_q <= 1'b1;
  end

  // Lockable fields refuse writes once frozen
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      poll_q  <= mcs_pkg::CTRL_RESET[mcs_pkg::POLL_BIT];
      alert_q <= mcs_pkg::CTRL_RESET[mcs_pkg::ALERT_BIT];
    end
    else if (do_wr && hit_ctrl && !lock_q)
    begin
      poll_q  <= hwdata[mcs_pkg::POLL_BIT];
      alert_q <= hwdata[mcs_pkg::ALERT_BIT];
    end
  end

  // Ready: the bank is usable from the first edge after reset
  // There is no slow power-up sequence in this bank, so ready stays
  // one; sensing blocks with a start-up delay would gate it here
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rdy_q <= mcs_pkg::CTRL_RESET[mcs_pkg::RDY_BIT];
    else
      rdy_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Outputs to the monitor
  // ----------------------------------------------------------------
  // Limit registers live elsewhere; this bank only tells them which set
  // to use and whether they are frozen, so clearing run keeps them.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      monitor_run         <= mcs_pkg::CTRL_RESET[mcs_pkg::RUN_BIT];
      use_prog_limits     <= mcs_pkg::CTRL_RESET[mcs_pkg::RUN_BIT];
      limits_frozen       <= mcs_pkg::CTRL_RESET[mcs_pkg::LOCK_BIT];
      cpu_thermal_poll_en <= mcs_pkg::CTRL_RESET[mcs_pkg::POLL_BIT];
    end
    else
    begin
      monitor_run         <= run_q;
      use_prog_limits     <= run_q;
      limits_frozen       <= lock_q;
      cpu_thermal_poll_en <= poll_q;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // Shared pin picks which event feeds bit 0
  assign bit0_cond = pin_is_alert ? alert_timer_cond : v2p5_cond;

  // Highest bit first, matching the status register layout
  assign stat_cond = {remote2_cond, local_cond, remote1_cond,
                      v5_cond, supply_volt_cond, core_volt_cond,
                      bit0_cond};

  // Clear happens at the same edge that captures read data
  assign stat_rd_clr = do_rd && hit_stat;

  // Read and clear share one edge; an event landing on that edge is
  // kept because the live condition is loaded rather than zero
  mcs_status_flags #(
    .WIDTH (mcs_pkg::STAT_COND_W)
  ) u_flags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cond    (stat_cond),
    .rd_clr  (stat_rd_clr),
    .flags_q (stat_flags)
  );

  // Summary tracks the second register live; it is not sticky here
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      summary_q <= mcs_pkg::STAT_RESET[mcs_pkg::SUMMARY_BIT];
    else
      summary_q <= |status2_bits;
  end

  // No write path exists to the status register
  assign stat_view = {summary_q, stat_flags};

  // ----------------------------------------------------------------
  // Fan override stage
  // ----------------------------------------------------------------
  // Full duty is the safe side: a stopped monitor, the override or an
  // enabled alert each pin every channel high, whatever the loop says
  assign ctl_bus.run        = run_q;
  assign ctl_bus.boost      = boost_q;
  // Alert override only acts when enabled, whatever the channel mode
  assign ctl_bus.alert_full = alert_q && (thermal_alert_in || cpu_ctrl_limit);

  mcs_fan_ctrl #(
    .FAN_COUNT (FAN_COUNT),
    .DUTY_W    (DUTY_W)
  ) u_fan (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ctl       (ctl_bus.fan),
    .calc_duty (calc_duty),
    .duty_q    (fan_duty)
  );
endmodule

// ---- hw/mcs_pkg.sv ----
// Constants for the monitor configuration and first status register bank
// Operation
// - Run set: monitoring on, fans follow duty from programmed limits.
// - Run clear: monitoring stops, limits fall back to power-up defaults.
// - Clearing run never alters any programmed limit register.
// - Run clear drives every fan output at full duty.
// - Freeze is set once; lockable registers stay read-only until power cycles.
// - After freeze, writes to lockable fields are ignored, control included.
// - Run field stays writable after the freeze.
// - Power-up done bit reads 1 once the device can monitor.
// - Full override set: every fan at full duty over all other settings.
// - Full override cleared: fans return to their computed duty.
// - Full override stays writable after the freeze.
// - Thermal poll enable turns on processor polling; locks with the freeze.
// - Alert override: alert or control limit forces full duty; locks with freeze.
// - Control register loads 0x04 at power-on.
// - Status register loads 0x00 at power-on and is read-only.
// - A status read clears a flag only if its condition is gone.
// - Bits 0 to 3 latch voltage high or low limit violations.
// - With the pin as thermal input, bit 0 latches the timer limit event.
// - Bits 4 and 6 latch remote 1 and remote 2 temperature violations.
// - Bit 5 latches local temperature violations.
// - Bit 7 is the OR of all second status register bits.
package mcs_pkg;
  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_IDX   = 8'h40;
  localparam logic [7:0]  STAT1_IDX  = 8'h41;
  localparam logic [9:0]  CTRL_ADDR  = {CTRL_IDX, 2'h0};
  localparam logic [9:0]  STAT1_ADDR = {STAT1_IDX, 2'h0};
  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int          RUN_BIT    = 0;
  localparam int          LOCK_BIT   = 1;
  localparam int          RDY_BIT    = 2;
  localparam int          BOOST_BIT  = 3;
  localparam int          POLL_BIT   = 4;
  localparam int          ALERT_BIT  = 5;
  localparam logic [7:0]  CTRL_RESET = 8'h04;
  localparam logic [7:0]  STAT_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int          STAT_COND_W  = 7;
  localparam int          SUMMARY_BIT  = 7;
  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage

// ---- hw/mcs_ctl_if.sv ----
// Fan override controls passed from the register core to the fan stage
`timescale 1ns/1ps
interface mcs_ctl_if;
  logic run;
  logic boost;
  logic alert_full;
  modport core (output run, output boost, output alert_full);
  modport fan  (input run, input boost, input alert_full);
endinterface

// ---- hw/mcs_status_flags.sv ----
// Sticky limit flags with clear-on-read only once the condition is gone
`timescale 1ns/1ps
module mcs_status_flags #(
  parameter int WIDTH = 7
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic             rd_clr,
  output logic      [WIDTH-1:0] flags_q
);
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_chk
    $error("mcs_status_flags: WIDTH must be 1 to 8");
  end

  // A live condition always wins over the read clear, so no event is lost
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      flags_q <= '0;
    else if (rd_clr)
      flags_q <= cond;
    else
      flags_q <= flags_q | cond;
  end
endmodule

// ---- hw/mcs_fan_ctrl.sv ----
// Per-channel fan duty selection with full-duty overrides
`timescale 1ns/1ps
module mcs_fan_ctrl #(
  parameter int FAN_COUNT = 3,
  parameter int DUTY_W    = 8
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  mcs_ctl_if.fan                             ctl,
  input  wire logic [FAN_COUNT-1:0][DUTY_W-1:0] calc_duty,
  output logic      [FAN_COUNT-1:0][DUTY_W-1:0] duty_q
);
  if (FAN_COUNT < 1 || DUTY_W < 2)
  begin : g_chk
    $error("mcs_fan_ctrl: FAN_COUNT >= 1 and DUTY_W >= 2 required");
  end

  logic force_full;

  // Any override pins all channels; fans start at full for safety
  assign force_full = !ctl.run || ctl.boost || ctl.alert_full;

  for (genvar i = 0; i < FAN_COUNT; i++)
  begin : g_ch
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        duty_q[i] <= '1;
      else if (force_full)
        duty_q[i] <= '1;
      else
        duty_q[i] <= calc_duty[i];
    end
  end
endmodule

// ---- verif/mcs_bank_properties.sv ----
// Port checker for the monitor control and status bank
`timescale 1ns/1ps
module mcs_bank_properties #(
  parameter int FAN_COUNT = 3,
  parameter int DUTY_W    = 8
) (
  input wire logic                              ref_clk,
  input wire logic                              reset,
  input wire logic                              hsel,
  input wire logic [31:0]                       haddr,
  input wire logic [1:0]                        htrans,
  input wire logic                              hwrite,
  input wire logic                              hready,
  input wire logic                              hreadyout,
  input wire logic [31:0]                       hrdata,
  input wire logic [FAN_COUNT-1:0][DUTY_W-1:0]  calc_duty,
  input wire logic [FAN_COUNT-1:0][DUTY_W-1:0]  fan_duty,
  input wire logic                              monitor_run,
  input wire logic                              use_prog_limits,
  input wire logic                              limits_frozen,
  input wire logic                              cpu_thermal_poll_en
);
  // ------------------------------------------------------------
  // Control read tracking
  // ------------------------------------------------------------
  logic pend_q;
  logic low_q;
  logic ctrl_done;
  // Follow a control read until its wait state has passed
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pend_q <= 1'b0;
      low_q  <= 1'b0;
    end
    else if (hsel && hready && htrans == mcs_pkg::HTRANS_NONSEQ)
    begin
      pend_q <= !hwrite && haddr[9:0] == mcs_pkg::CTRL_ADDR;
      low_q  <= 1'b0;
    end
    else if (!hreadyout)
      low_q <= 1'b1;
    else if (low_q)
      pend_q <= 1'b0;
  end
  // Edge at which the master takes the control read data
  assign ctrl_done = pend_q && low_q && hreadyout;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_stop_fans_full: assert property (!monitor_run |-> fan_duty == '1)
    else $error("fans below full duty while stopped");
  a_limit_select: assert property (use_prog_limits == monitor_run)
    else $error("limit select differs from run");
  a_fan_follow: assert property (monitor_run |-> fan_duty == '1 || fan_duty == $past(calc_duty))
    else $error("fan duty neither full nor computed");
  a_freeze_sticks: assert property (limits_frozen |=> limits_frozen)
    else $error("freeze cleared without reset");
  a_poll_locked: assert property (limits_frozen |=> $stable(cpu_thermal_poll_en))
    else $error("poll enable changed while frozen");
  a_ready_reads: assert property (ctrl_done |-> hrdata[mcs_pkg::RDY_BIT])
    else $error("ready bit read as zero");
  a_resv_zero: assert property (ctrl_done |-> hrdata[31:6] == 26'h0)
    else $error("reserved control bits not zero");
  a_ctrl_mirror: assert property (ctrl_done |-> hrdata[0] == monitor_run && hrdata[1] == limits_frozen)
    else $error("control read differs from outputs");
endmodule

bind mcs_bank mcs_bank_properties #(.FAN_COUNT(FAN_COUNT), .DUTY_W(DUTY_W)) u_props (
  .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .calc_duty(calc_duty), .fan_duty(fan_duty), .monitor_run(monitor_run),
  .use_prog_limits(use_prog_limits), .limits_frozen(limits_frozen),
  .cpu_thermal_poll_en(cpu_thermal_poll_en)
);

// ---- verif/mcs_bank_test.sv ----
// Self-checking bench for the monitor control and status bank
`timescale 1ns/1ps
module mcs_bank_test;
  localparam logic [9:0]  CA   = mcs_pkg::CTRL_ADDR;
  localparam logic [9:0]  SA   = mcs_pkg::STAT1_ADDR;
  localparam logic [23:0] CALC = 24'h5A3C17;
  logic            ref_clk = 1'b0;
  logic            reset = 1'b1;
  logic            hsel = 1'b0;
  logic [31:0]     haddr = 32'h0;
  logic [1:0]      htrans = 2'h0;
  logic            hwrite = 1'b0;
  logic [31:0]     hwdata = 32'h0;
  logic            hreadyout;
  logic [31:0]     hrdata;
  logic            hresp;
  logic [7:0]      cv = 8'h0;
  logic            pin_is_alert = 1'b0;
  logic [7:0]      status2_bits = 8'h0;
  logic            thermal_alert_in = 1'b0;
  logic            cpu_ctrl_limit = 1'b0;
  logic [2:0][7:0] calc_duty = CALC;
  logic [2:0][7:0] fan_duty;
  logic            monitor_run;
  logic            use_prog_limits;
  logic            limits_frozen;
  logic            cpu_thermal_poll_en;
  logic [31:0]     rd;
  logic [31:0]     e;
  int              err_count = 0;
  int              total_checks = 0;
  int              cycles = 0;

  mcs_bank dut (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(mcs_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .v2p5_cond(cv[0]),
    .alert_timer_cond(cv[7]), .pin_is_alert(pin_is_alert), .core_volt_cond(cv[1]),
    .supply_volt_cond(cv[2]), .v5_cond(cv[3]), .remote1_cond(cv[4]), .local_cond(cv[5]),
    .remote2_cond(cv[6]), .status2_bits(status2_bits), .thermal_alert_in(thermal_alert_in),
    .cpu_ctrl_limit(cpu_ctrl_limit), .calc_duty(calc_duty), .fan_duty(fan_duty),
    .monitor_run(monitor_run), .use_prog_limits(use_prog_limits),
    .limits_frozen(limits_frozen), .cpu_thermal_poll_en(cpu_thermal_poll_en)
  );

  // ------------------------------------------------------------
  // Clock, timeout and reporting
  // ------------------------------------------------------------
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hung run short, well above the expected length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    total_checks++;
    if (got !== x)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
    end
  endtask
  // Single AHB-Lite word transfer; waits for hready in both phases
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    hwrite <= wr;
    htrans <= mcs_pkg::HTRANS_NONSEQ;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 50)
      chk("bus wait", 32'h0, 32'h1);
  endtask
  task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(nm, x, rd);
  endtask
  // Let the fan stage settle, then compare against full or computed duty
  task automatic fchk(input logic full);
    repeat (3) @(posedge ref_clk);
    chk("fan_duty", full ? 32'hFFFFFF : {8'h0, CALC}, {8'h0, fan_duty});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rchk("ctrl reset", CA, 32'h04);
    rchk("status reset", SA, 32'h00);
    fchk(1'b1);
    xfer(1'b1, SA, 32'hFF);
    rchk("status read only", SA, 32'h00);
    rchk("unmapped", 10'h108, 32'h0);
    xfer(1'b1, CA, 32'hF9);
    rchk("ctrl fields", CA, 32'h3D);
    fchk(1'b1);
    chk("poll", 32'h1, {31'h0, cpu_thermal_poll_en});
    xfer(1'b1, CA, 32'h01);
    rchk("ctrl run", CA, 32'h05);
    fchk(1'b0);
    chk("prog limits", 32'h1, {31'h0, use_prog_limits});
    chk("monitor run", 32'h1, {31'h0, monitor_run});
    thermal_alert_in <= 1'b1;
    fchk(1'b0);
    xfer(1'b1, CA, 32'h21);
    fchk(1'b1);
    thermal_alert_in <= 1'b0;
    cpu_ctrl_limit <= 1'b1;
    fchk(1'b1);
    cpu_ctrl_limit <= 1'b0;
    fchk(1'b0);
    xfer(1'b1, CA, 32'h00);
    fchk(1'b1);
    chk("prog limits", 32'h0, {31'h0, use_prog_limits});
    // Each flag: held while the condition stays, cleared by the read after it goes
    for (int i = 0; i < 8; i++)
    begin
      e = (i == 7) ? 32'h1 : 32'h1 << i;
      pin_is_alert <= (i == 7);
      cv <= 8'h1 << i;
      repeat (2) @(posedge ref_clk);
      rchk("flag set", SA, e);
      rchk("flag held", SA, e);
      cv <= 8'h0;
      @(posedge ref_clk);
      rchk("flag latched", SA, e);
      rchk("flag cleared", SA, 32'h0);
    end
    cv <= 8'h01;
    repeat (2) @(posedge ref_clk);
    rchk("pin as thermal", SA, 32'h0);
    cv <= 8'h0;
    status2_bits <= 8'h10;
    repeat (2) @(posedge ref_clk);
    rchk("summary set", SA, 32'h80);
    status2_bits <= 8'h0;
    repeat (2) @(posedge ref_clk);
    rchk("summary clear", SA, 32'h0);
    // Freeze, then try to change every field
    xfer(1'b1, CA, 32'h13);
    @(posedge ref_clk);
    chk("frozen", 32'h1, {31'h0, limits_frozen});
    xfer(1'b1, CA, 32'h28);
    rchk("ctrl locked", CA, 32'h1E);
    fchk(1'b1);
    xfer(1'b1, CA, 32'h01);
    rchk("run after lock", CA, 32'h17);
    fchk(1'b0);
    end_of_test();
  end
endmodule
